// *** verilog/msst_regs.vh ***
// msst_regs.vh - constants for the subtract/swap/skip/table/xor execution unit
// assumes: included by bare name from every design file of this block
`ifndef MSST_REGS_VH
`define MSST_REGS_VH

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define MSST_OFF_ACC      8'h00
`define MSST_OFF_FLAGS    8'h04
`define MSST_OFF_TBLPTR   8'h08
`define MSST_OFF_TBLHIGH  8'h0C
`define MSST_OFF_MEMADDR  8'h10
`define MSST_OFF_MEMDATA  8'h14
`define MSST_OFF_STATUS   8'h18

// ----------------------------------------
// flag bit positions in the flags register
// ----------------------------------------
`define MSST_FLAG_C       0
`define MSST_FLAG_HC      1
`define MSST_FLAG_Z       2
`define MSST_FLAG_OVF     3

// ----------------------------------------
// reset values
// ----------------------------------------
`define MSST_RST_BYTE     8'h00
`define MSST_RST_FLAGS    4'h0
`define MSST_RST_MADDR    6'h00

// ----------------------------------------
// widths
// ----------------------------------------
`define MSST_PCW          10
`define MSST_DMAW         6
`define MSST_DMDEPTH      64

// ----------------------------------------
// operation codes from the decoder
// ----------------------------------------
`define MSST_OP_NOP       4'h0
`define MSST_OP_SUB_A_M   4'h1
`define MSST_OP_SUB_M     4'h2
`define MSST_OP_SUB_A_X   4'h3
`define MSST_OP_SWAP      4'h4
`define MSST_OP_SWAP_A    4'h5
`define MSST_OP_SKZ       4'h6
`define MSST_OP_SKZA      4'h7
`define MSST_OP_SKB_CLR   4'h8
`define MSST_OP_SKB_SET   4'h9
`define MSST_OP_TRD_CUR   4'hA
`define MSST_OP_TRD_LAST  4'hB
`define MSST_OP_XOR_A_M   4'hC
`define MSST_OP_XOR_M     4'hD
`define MSST_OP_XOR_A_X   4'hE

`endif

// *** verilog/msst_alu.v ***
// msst_alu.v - combinational result, flag and skip logic for one instruction
// assumes: operands are stable for the cycle the instruction is taken
`timescale 1ns/1ps
`include "msst_regs.vh"

module msst_alu (
  // instruction and operands
  input  wire [3:0] op,
  input  wire [7:0] acc_in,
  input  wire [7:0] mem_in,
  input  wire [7:0] imm_in,
  input  wire [2:0] bit_sel,
  input  wire [3:0] flags_in,
  // results
  output reg  [7:0] result,
  output reg        to_acc,
  output reg        to_mem,
  output reg  [3:0] flags_out,
  output reg        skip
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // a + ~b + 1, returns {ovf, hc, c, diff}
  function [10:0] sub_calc;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    reg   [4:0] l;
    begin
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      sub_calc = {(a[7] == ~b[7]) && (s[7] != a[7]), l[4], s[8], s[7:0]};
    end
  endfunction

  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  reg [10:0] sub_r;   // subtract outcome
  reg [7:0]  sub_b;   // subtrahend: memory or immediate

  // ----------------------------------------
  // operation select
  // ----------------------------------------
  always @* begin
    sub_b     = (op == `MSST_OP_SUB_A_X) ? imm_in : mem_in;
    sub_r     = sub_calc(acc_in, sub_b);
    result    = 8'h00;
    to_acc    = 1'b0;
    to_mem    = 1'b0;
    flags_out = flags_in;   // untouched unless a case says so
    skip      = 1'b0;
    case (op)
      `MSST_OP_SUB_A_M, `MSST_OP_SUB_A_X, `MSST_OP_SUB_M: begin
        result = sub_r[7:0];
        to_acc = (op != `MSST_OP_SUB_M);
        to_mem = (op == `MSST_OP_SUB_M);
        flags_out[`MSST_FLAG_OVF] = sub_r[10];
        flags_out[`MSST_FLAG_HC] = sub_r[9];
        flags_out[`MSST_FLAG_C]  = sub_r[8];              // carry, not borrow
        flags_out[`MSST_FLAG_Z]  = is_zero(sub_r[7:0]);
      end
      `MSST_OP_SWAP: begin
        result = {mem_in[3:0], mem_in[7:4]};
        to_mem = 1'b1;
      end
      `MSST_OP_SWAP_A: begin
        result = {mem_in[3:0], mem_in[7:4]};
        to_acc = 1'b1;
      end
      `MSST_OP_SKZ: begin
        skip = is_zero(mem_in);
      end
      `MSST_OP_SKZA: begin
        result = mem_in;
        to_acc = 1'b1;
        skip   = is_zero(mem_in);
      end
      `MSST_OP_SKB_CLR: begin
        skip = ~mem_in[bit_sel];
      end
      `MSST_OP_SKB_SET: begin
        skip = mem_in[bit_sel];
      end
      `MSST_OP_XOR_A_M, `MSST_OP_XOR_M, `MSST_OP_XOR_A_X: begin
        result = acc_in ^ ((op == `MSST_OP_XOR_A_X) ? imm_in : mem_in);
        to_acc = (op != `MSST_OP_XOR_M);
        to_mem = (op == `MSST_OP_XOR_M);
        flags_out[`MSST_FLAG_Z] = is_zero(result);
      end
      default: begin
        result = 8'h00;   // nop and table reads handled by the sequencer
      end
    endcase
  end

endmodule // msst_alu

// *** verilog/msst_dmem.v ***
// msst_dmem.v - small data memory, one write port and two read ports
// assumes: single clock, writes gated by the caller's clock enable
`timescale 1ns/1ps
`include "msst_regs.vh"

module msst_dmem (
  // clock
  input  wire                     clk_sys,
  // write port
  input  wire                     wr_en,
  input  wire [`MSST_DMAW-1:0]    wr_addr,
  input  wire [7:0]               wr_data,
  // read ports, asynchronous
  input  wire [`MSST_DMAW-1:0]    rd_addr_a,
  output wire [7:0]               rd_data_a,
  input  wire [`MSST_DMAW-1:0]    rd_addr_b,
  output wire [7:0]               rd_data_b
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] mem [0:`MSST_DMDEPTH-1];   // contents undefined after reset

  // write on the rising edge
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

endmodule // msst_dmem

// *** verilog/msst_exec.v ***
// msst_exec.v - execution unit for subtract, nibble swap, conditional skip,
// table read and exclusive-or instructions, with an apb register window
// assumes: decoder inputs and apb are synchronous to clk_sys; program
// memory answers a read combinationally, within the cycle that rom_rd is high
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "msst_regs.vh"

// What this block does
// - bit set: skip next, flags unchanged
// - taken skip discards prefetch, adds dummy cycle
// - acc minus memory into acc, four flags
// - acc minus memory into memory, four flags
// - acc minus immediate into acc, four flags
// - swap memory nibbles in place, no flags
// - swapped memory nibbles into acc, no flags
// - memory zero: skip next, nothing changed
// - copy memory to acc, skip if zero
// - bit clear: skip next, flags unchanged
// - current page table read to memory, high byte
// - last page table read, same transfer
// - acc xor memory into acc, zero flag
// - acc xor memory into memory, zero flag
// - acc xor immediate into acc, zero flag
module msst_exec (
  // clock, reset, enable
  input  wire                  clk_sys,
  input  wire                  rst,
  input  wire                  ce,
  // apb slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [7:0]            paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // instruction from decoder
  input  wire                  ins_valid,
  input  wire [3:0]            ins_op,
  input  wire [`MSST_DMAW-1:0] ins_addr,
  input  wire [2:0]            ins_bit,
  input  wire [7:0]            ins_imm,
  input  wire [`MSST_PCW-1:0]  ins_pc,
  output reg                   ins_ready,
  output reg                   skip_taken,
  // program memory read port
  output reg  [`MSST_PCW-1:0]  rom_addr,
  output reg                   rom_rd,
  input  wire [15:0]           rom_data,
  // architectural state
  output reg  [7:0]            accumulator_reg,
  output reg  [7:0]            table_pointer,
  output reg  [7:0]            table_high_byte,
  output reg                   overflow_flag,
  output reg                   zero_flag,
  output reg                   aux_carry_flag,
  output reg                   carry_flag
);

  // ----------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------
  localparam [2:0] ST_RUN   = 3'b001;   // accepting instructions
  localparam [2:0] ST_DUMMY = 3'b010;   // discarded prefetch slot
  localparam [2:0] ST_TBL   = 3'b100;   // waiting for program word

  reg  [2:0]            state;        // current state
  reg  [2:0]            next_state;   // state for next edge
  reg  [`MSST_DMAW-1:0] tbl_dest;     // memory byte for table low byte
  reg  [`MSST_DMAW-1:0] mem_addr;     // apb window into data memory
  reg  [7:0]            skip_count;   // taken skips, wraps

  // ----------------------------------------
  // combinational glue
  // ----------------------------------------
  wire       take = ins_valid & ins_ready;                     // instruction taken
  wire [3:0] flags_now = {overflow_flag, zero_flag, aux_carry_flag, carry_flag};
  wire       is_tbl = (ins_op == `MSST_OP_TRD_CUR) | (ins_op == `MSST_OP_TRD_LAST);

  wire [7:0] mem_rd_exec;   // operand byte at ins_addr
  wire [7:0] mem_rd_apb;    // byte under apb window

  wire [7:0] alu_res;       // alu result byte
  wire       alu_to_acc;    // result goes to accumulator
  wire       alu_to_mem;    // result goes to memory
  wire [3:0] alu_flags;     // flags after the operation
  wire       alu_skip;      // skip condition met

  // apb access phase completes at this edge
  wire       apb_done = psel & penable & pready;
  wire       apb_wr   = apb_done & pwrite;

  // ----------------------------------------
  // address decode, shared by read and write paths
  // ----------------------------------------
  function mapped;
    input [7:0] a;
    begin
      case (a)
        `MSST_OFF_ACC, `MSST_OFF_FLAGS, `MSST_OFF_TBLPTR, `MSST_OFF_TBLHIGH,
        `MSST_OFF_MEMADDR, `MSST_OFF_MEMDATA, `MSST_OFF_STATUS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // alu and data memory
  // ----------------------------------------
  msst_alu u_alu (
    .op        (take ? ins_op : `MSST_OP_NOP),
    .acc_in    (accumulator_reg),
    .mem_in    (mem_rd_exec),
    .imm_in    (ins_imm),
    .bit_sel   (ins_bit),
    .flags_in  (flags_now),
    .result    (alu_res),
    .to_acc    (alu_to_acc),
    .to_mem    (alu_to_mem),
    .flags_out (alu_flags),
    .skip      (alu_skip)
  );

  // memory write select: execution beats apb, since a stalled core
  // is worse than a lost debug poke
  reg                  next_wr_en;     // memory write this cycle
  reg [`MSST_DMAW-1:0] next_wr_addr;   // memory write address
  reg [7:0]            next_wr_data;   // memory write byte

  always @* begin
    next_wr_en   = 1'b0;
    next_wr_addr = ins_addr;
    next_wr_data = alu_res;
    if (!ce) begin
      next_wr_en = 1'b0;                                       // frozen
    end else if (state == ST_TBL) begin
      next_wr_en   = 1'b1;
      next_wr_addr = tbl_dest;
      next_wr_data = rom_data[7:0];
    end else if (alu_to_mem) begin
      next_wr_en = 1'b1;
    end else if (apb_wr && paddr == `MSST_OFF_MEMDATA) begin
      next_wr_en   = 1'b1;
      next_wr_addr = mem_addr;
      next_wr_data = pwdata[7:0];
    end
  end

  msst_dmem u_dmem (
    .clk_sys   (clk_sys),
    .wr_en     (next_wr_en),
    .wr_addr   (next_wr_addr),
    .wr_data   (next_wr_data),
    .rd_addr_a (ins_addr),
    .rd_data_a (mem_rd_exec),
    .rd_addr_b (mem_addr),
    .rd_data_b (mem_rd_apb)
  );

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (take && is_tbl) begin
          next_state = ST_TBL;                                 // word fetch cycle
        end else if (take && alu_skip) begin
          next_state = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        next_state = ST_RUN;                                   // one dummy only
      end
      ST_TBL: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer, table read and skip signalling
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      state      <= ST_RUN;
      ins_ready  <= 1'b1;
      skip_taken <= 1'b0;
      rom_addr   <= {`MSST_PCW{1'b0}};
      rom_rd     <= 1'b0;
      tbl_dest   <= `MSST_RST_MADDR;
      skip_count <= `MSST_RST_BYTE;
    end else if (ce) begin
      state      <= next_state;
      ins_ready  <= (next_state == ST_RUN);                    // stall in dummy/table
      skip_taken <= (next_state == ST_DUMMY);                  // marks the discard
      rom_rd     <= (next_state == ST_TBL);
      if (state == ST_RUN && take && is_tbl) begin
        tbl_dest <= ins_addr;
        if (ins_op == `MSST_OP_TRD_CUR) begin
          rom_addr <= {ins_pc[`MSST_PCW-1:8], table_pointer};
        end else begin
          rom_addr <= {{(`MSST_PCW-8){1'b1}}, table_pointer};
        end
      end
      if (state == ST_RUN && take && alu_skip) begin
        skip_count <= skip_count + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // accumulator, flags, table registers
  // ----------------------------------------
  // instruction results win over an apb write in the same cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      accumulator_reg <= `MSST_RST_BYTE;
      table_pointer   <= `MSST_RST_BYTE;
      table_high_byte <= `MSST_RST_BYTE;
      overflow_flag   <= 1'b0;
      zero_flag       <= 1'b0;
      aux_carry_flag  <= 1'b0;
      carry_flag      <= 1'b0;
      mem_addr        <= `MSST_RST_MADDR;
    end else if (ce) begin
      // accumulator
      if (alu_to_acc) begin
        accumulator_reg <= alu_res;
      end else if (apb_wr && paddr == `MSST_OFF_ACC) begin
        accumulator_reg <= pwdata[7:0];
      end
      // flags: the alu passes unaffected bits through untouched
      if (take) begin
        overflow_flag  <= alu_flags[`MSST_FLAG_OVF];
        zero_flag      <= alu_flags[`MSST_FLAG_Z];
        aux_carry_flag <= alu_flags[`MSST_FLAG_HC];
        carry_flag     <= alu_flags[`MSST_FLAG_C];
      end else if (apb_wr && paddr == `MSST_OFF_FLAGS) begin
        overflow_flag  <= pwdata[`MSST_FLAG_OVF];
        zero_flag      <= pwdata[`MSST_FLAG_Z];
        aux_carry_flag <= pwdata[`MSST_FLAG_HC];
        carry_flag     <= pwdata[`MSST_FLAG_C];
      end
      // table high byte only from a table read
      if (state == ST_TBL) begin
        table_high_byte <= rom_data[15:8];
      end
      if (apb_wr && paddr == `MSST_OFF_TBLPTR) begin
        table_pointer <= pwdata[7:0];
      end
      if (apb_wr && paddr == `MSST_OFF_MEMADDR) begin
        mem_addr <= pwdata[`MSST_DMAW-1:0];
      end
    end
  end

  // ----------------------------------------
  // apb read data and handshake
  // ----------------------------------------
  // ready is raised one cycle into the access phase, so every
  // transfer takes setup plus two access cycles
  reg [31:0] next_prdata;   // read value for the addressed register

  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `MSST_OFF_ACC: begin
        next_prdata = {24'h00_0000, accumulator_reg};
      end
      `MSST_OFF_FLAGS: begin
        next_prdata = {28'h000_0000, flags_now};
      end
      `MSST_OFF_TBLPTR: begin
        next_prdata = {24'h00_0000, table_pointer};
      end
      `MSST_OFF_TBLHIGH: begin
        next_prdata = {24'h00_0000, table_high_byte};
      end
      `MSST_OFF_MEMADDR: begin
        next_prdata = {26'h000_0000, mem_addr};
      end
      `MSST_OFF_MEMDATA: begin
        next_prdata = {24'h00_0000, mem_rd_apb};
      end
      `MSST_OFF_STATUS: begin
        next_prdata = {21'h00_0000, state, skip_count};
      end
      default: begin
        next_prdata = 32'h0000_0000;   // unmapped reads as zero
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel & penable & ~pready;                      // one pulse per access
      if (psel && penable && !pready) begin
        pslverr <= ~mapped(paddr);
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

endmodule // msst_exec

// *** tb/msst_exec_assertions.sv ***
// msst_exec_assertions.sv - port-level checks on the execution unit
// assumes: bound into msst_exec, one clk_sys domain, rst synchronous
`timescale 1ns/1ps
`include "msst_regs.vh"

module msst_exec_checker (
  // clock and reset
  input wire                 clk_sys,
  input wire                 rst,
  input wire                 ce,
  // instruction port
  input wire                 ins_valid,
  input wire [3:0]           ins_op,
  input wire [7:0]           ins_imm,
  input wire [`MSST_PCW-1:0] ins_pc,
  input wire                 ins_ready,
  input wire                 skip_taken,
  // table read and state
  input wire [`MSST_PCW-1:0] rom_addr,
  input wire                 rom_rd,
  input wire [7:0]           accumulator_reg,
  input wire [7:0]           table_pointer,
  input wire                 overflow_flag,
  input wire                 zero_flag,
  input wire                 aux_carry_flag,
  input wire                 carry_flag
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wire       take = ins_valid && ins_ready && ce; // edge that accepts an op
  wire [3:0] flg  = {overflow_flag, zero_flag, aux_carry_flag, carry_flag};
  wire [1:0] page = ins_pc[9:8];                  // page of the op itself

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_skip_one_dummy: assert property (skip_taken && ce |=> !skip_taken)
    else $error("dummy cycle lasted more than one cycle");
  a_skip_blocks_take: assert property (skip_taken |-> !ins_ready)
    else $error("instruction accepted during dummy cycle");
  a_skip_has_cause: assert property ($rose(skip_taken) |->
    $past(ins_op) >= `MSST_OP_SKZ && $past(ins_op) <= `MSST_OP_SKB_SET)
    else $error("dummy cycle without a skip op");
  a_copy_skip_zero: assert property (take && ins_op == `MSST_OP_SKZA |=>
    skip_taken == (accumulator_reg == 8'h00))
    else $error("copy and test skip disagrees with loaded byte");
  a_sub_imm_acc: assert property (take && ins_op == `MSST_OP_SUB_A_X |=>
    accumulator_reg == $past(accumulator_reg) - $past(ins_imm) &&
    carry_flag == ($past(accumulator_reg) >= $past(ins_imm)))
    else $error("immediate subtract result or carry wrong");
  a_xor_imm_zero: assert property (take && ins_op == `MSST_OP_XOR_A_X |=>
    accumulator_reg == ($past(accumulator_reg) ^ $past(ins_imm)) &&
    zero_flag == (accumulator_reg == 8'h00) && (flg & 4'hB) == ($past(flg) & 4'hB))
    else $error("immediate xor result or flags wrong");
  a_tab_cur_addr: assert property (take && ins_op == `MSST_OP_TRD_CUR |=>
    rom_rd && rom_addr == {$past(page), $past(table_pointer)})
    else $error("current page table address wrong");
  a_tab_last_addr: assert property (take && ins_op == `MSST_OP_TRD_LAST |=>
    rom_rd && rom_addr == {2'b11, $past(table_pointer)})
    else $error("last page table address wrong");
  a_tab_flags_kept: assert property (take && ins_op[3:1] == 3'b101 |=>
    ##1 flg == $past(flg, 2))
    else $error("table read changed a flag");
  a_quiet_flags: assert property (take && ins_op >= `MSST_OP_SWAP &&
    ins_op <= `MSST_OP_SKB_SET |=> flg == $past(flg))
    else $error("swap or skip changed a flag");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_skip: cover property (skip_taken);
  c_table: cover property (rom_rd);
  c_zero: cover property (take && ins_op == `MSST_OP_SKZA ##1 skip_taken);
endmodule // msst_exec_checker

bind msst_exec msst_exec_checker chk_u (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .ins_valid(ins_valid), .ins_op(ins_op),
  .ins_imm(ins_imm), .ins_pc(ins_pc), .ins_ready(ins_ready), .skip_taken(skip_taken),
  .rom_addr(rom_addr), .rom_rd(rom_rd), .accumulator_reg(accumulator_reg),
  .table_pointer(table_pointer), .overflow_flag(overflow_flag), .zero_flag(zero_flag),
  .aux_carry_flag(aux_carry_flag), .carry_flag(carry_flag)
);

// *** tb/test_mcu_subtract_swap_skip_table_ops.sv ***
// test_mcu_subtract_swap_skip_table_ops.sv - directed bench for the execution unit
// assumes: msst_exec and msst_dmem compiled alongside, checker bound to it
`timescale 1ns/1ps
`include "msst_regs.vh"

module test_mcu_subtract_swap_skip_table_ops;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, t;
  logic        pready, pslverr, ins_ready, skip_taken, rom_rd;
  logic        ins_valid = 1'b0;
  logic [3:0]  ins_op = 4'h0, fl;
  logic [2:0]  ins_bit = 3'h0;
  logic [7:0]  ins_imm = 8'h00, acc, tptr, thi;
  logic [9:0]  ins_pc = 10'h000, rom_addr;
  logic        ovf, zf, acf, cf;
  logic [20:0] e;      // {skip, flags, acc, mem} expected
  logic [15:0] w;
  int          failures = 0, checks_done = 0;
  wire  [3:0]  flg = {ovf, zf, acf, cf};
  // op, bit, acc, mem, immediate per vector
  logic [31:0] tv [27] = '{32'h10503000, 32'h10305000, 32'h10800100, 32'h10101000,
    32'h107FFF00, 32'h20503000, 32'h20305000, 32'h3050AA30, 32'h307F00FF, 32'h40113C00,
    32'h5011A500, 32'h60110000, 32'h60110100, 32'h70330000, 32'h70338000, 32'h80110E00,
    32'h87117F00, 32'h87118000, 32'h90110100, 32'h9311F700, 32'h97118000, 32'hC05AA500,
    32'hC03C3C00, 32'hD05AA500, 32'hD03C3C00, 32'hE03C113C, 32'hE05A3CA5};

  // program words carry their own address so a misrouted read shows
  function automatic logic [15:0] rom_word(input logic [9:0] a);
    return {a[7:0] ^ 8'hA5, a[9:8], a[5:0]};
  endfunction
  wire [15:0] rom_data = rom_word(rom_addr);

  // ----------------------------------------
  // device under test
  // ----------------------------------------
  msst_exec dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ins_valid(ins_valid), .ins_op(ins_op), .ins_addr(6'h05),
    .ins_bit(ins_bit), .ins_imm(ins_imm), .ins_pc(ins_pc), .ins_ready(ins_ready),
    .skip_taken(skip_taken), .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data),
    .accumulator_reg(acc), .table_pointer(tptr), .table_high_byte(thi),
    .overflow_flag(ovf), .zero_flag(zf), .aux_carry_flag(acf), .carry_flag(cf)
  );

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // reference model and tasks
  // ----------------------------------------
  // subtract as inverse plus one; returns {ovf, z, hc, c, result}
  function automatic logic [11:0] sub_exp(input logic [7:0] a, b);
    logic [8:0] s;
    logic [4:0] l;
    s = {1'b0, a} + {1'b0, ~b} + 9'h001;
    l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    return {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, l[4], s[8], s[7:0]};
  endfunction

  function automatic logic [20:0] model(input logic [3:0] op, input logic [7:0] a, m, x,
                                        input logic [2:0] bt, input logic [3:0] f);
    logic [11:0] s;
    s = sub_exp(a, op == `MSST_OP_SUB_A_X ? x : m);
    case (op)
      `MSST_OP_SUB_A_M: return {1'b0, s[11:8], s[7:0], m};
      `MSST_OP_SUB_A_X: return {1'b0, s[11:8], s[7:0], m};
      `MSST_OP_SUB_M:   return {1'b0, s[11:8], a, s[7:0]};
      `MSST_OP_SWAP:    return {1'b0, f, a, m[3:0], m[7:4]};
      `MSST_OP_SWAP_A:  return {1'b0, f, m[3:0], m[7:4], m};
      `MSST_OP_SKZ:     return {m == 8'h00, f, a, m};
      `MSST_OP_SKZA:    return {m == 8'h00, f, m, m};
      `MSST_OP_SKB_CLR: return {!m[bt], f, a, m};
      `MSST_OP_SKB_SET: return {m[bt], f, a, m};
      `MSST_OP_XOR_A_M: return {1'b0, f[3], (a ^ m) == 8'h00, f[1:0], a ^ m, m};
      `MSST_OP_XOR_M:   return {1'b0, f[3], (a ^ m) == 8'h00, f[1:0], a, a ^ m};
      default:          return {1'b0, f[3], (a ^ x) == 8'h00, f[1:0], a ^ x, m};
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; read data and error land in q and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      summarize();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // offer one instruction, then check the skip and dummy cycle timing
  task automatic exec(input logic [3:0] op, input logic [7:0] x, input logic [2:0] bt,
                      input logic [9:0] pc, input logic sk);
    int n;
    @(posedge clk_sys);
    ins_op <= op;
    ins_imm <= x;
    ins_bit <= bt;
    ins_pc <= pc;
    ins_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ins_ready !== 1'b1 && n < 20);
    if (ins_ready !== 1'b1) begin
      failures++;
      summarize();
    end
    ins_valid <= 1'b0;
    @(negedge clk_sys);
    check("skip_taken", skip_taken, sk);
    check("ins_ready", ins_ready, !(sk || op[3:1] == 3'b101));
    @(negedge clk_sys);
    check("ins_ready", ins_ready, 1'b1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("reset", {acc, tptr, thi, flg}, 28'h0);
    apb(0, 8'h1C, 32'h0);
    check("unmapped", q, 32'h0);
    check("pslverr", err, 1'b1);
    apb(1, `MSST_OFF_MEMADDR, 32'h5);
    // every arithmetic, swap and skip op; all but the two swap ops over both flag patterns
    for (int i = 0; i < 27; i++) begin
      t = tv[i];
      fl = i[0] ? 4'hB : 4'h4;
      e = model(t[31:28], t[23:16], t[15:8], t[7:0], t[26:24], fl);
      apb(1, `MSST_OFF_ACC, {24'h0, t[23:16]});
      apb(1, `MSST_OFF_MEMDATA, {24'h0, t[15:8]});
      apb(1, `MSST_OFF_FLAGS, {28'h0, fl});
      exec(t[31:28], t[7:0], t[26:24], 10'h000, e[20]);
      check("flags", flg, e[19:16]);
      check("acc", acc, e[15:8]);
      apb(0, `MSST_OFF_MEMDATA, 32'h0);
      check("mem", q, e[7:0]);
    end
    // table reads from the op's own page, then from the last page
    apb(1, `MSST_OFF_TBLPTR, 32'h9C);
    for (int f = 0; f < 2; f++) begin
      apb(1, `MSST_OFF_FLAGS, 32'h5);
      apb(1, `MSST_OFF_TBLHIGH, 32'hFF);
      exec(`MSST_OP_TRD_CUR + f, 8'h00, 3'h0, 10'h1F3, 1'b0);
      w = rom_word({f ? 2'b11 : 2'b01, 8'h9C});
      check("flags", flg, 4'h5);
      check("thi", thi, w[15:8]);
      apb(0, `MSST_OFF_MEMDATA, 32'h0);
      check("mem", q, w[7:0]);
      apb(0, `MSST_OFF_TBLHIGH, 32'h0);
      check("thi reg", q, w[15:8]);
    end
    summarize();
  end
endmodule // test_mcu_subtract_swap_skip_table_ops
